// ---- core/spc_defs.svh ----
// constants for the suspend plane control block
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH
`define SPC_CLK_HZ 100000000
`define SPC_DEBOUNCE_MS 16
`define SPC_DEBOUNCE_CYC ((`SPC_CLK_HZ / 1000) * `SPC_DEBOUNCE_MS)
`define SPC_SUSP_ON 4'h1
`define SPC_SUSP_POS 4'h2
`define SPC_SUSP_STR 4'h4
`define SPC_SUSP_STD 4'h8
`endif

// ---- core/spc_pkg.sv ----
// types for the suspend plane control block
package spc_pkg;
  typedef enum logic [3:0] {
    SPC_ON = 4'b0001,
    SPC_POS = 4'b0010,
    SPC_STR = 4'b0100,
    SPC_STD = 4'b1000
  } spc_state_e;
  typedef logic [1:0] spc_req_t;
  localparam spc_req_t SPC_REQ_ON = 2'h0;
  localparam spc_req_t SPC_REQ_POS = 2'h1;
  localparam spc_req_t SPC_REQ_STR = 2'h2;
  localparam spc_req_t SPC_REQ_STD = 2'h3;
endpackage

// ---- core/spc_suspend_plane_control.sv ----
// suspend plane pin logic: plane controls, clock stop, wake inputs
`timescale 1ns/1ps
`include "spc_defs.svh"
module spc_suspend_plane_control
  import spc_pkg::*;
#(
  parameter int CLK_HZ = `SPC_CLK_HZ,
  parameter int DEBOUNCE_CYC = (CLK_HZ / 1000) * `SPC_DEBOUNCE_MS
) (
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  input wire logic RESUME_RESET_N_IN,
  input wire logic [1:0] SUSPEND_REQ_IN,
  input wire logic PCI_STOP_REQ_IN,
  input wire logic CLKSTOP_GPO_SEL_IN,
  input wire logic SECONDARY_GPO_SEL_IN,
  input wire logic TERTIARY_GPO_SEL_IN,
  input wire logic GP_OUT_CLKSTOP_ALT_IN,
  input wire logic GP_OUT_SECONDARY_ALT_IN,
  input wire logic GP_OUT_TERTIARY_ALT_IN,
  input wire logic RING_GPI_SEL_IN,
  input wire logic ALERT_GPI_SEL_IN,
  input wire logic ALERT_IRQ_EN_IN,
  input wire logic ALERT_RESUME_EN_IN,
  input wire logic POWER_BUTTON_N_IN,
  input wire logic RING_INDICATE_N_IN,
  input wire logic SMBUS_ALERT_N_IN,
  input wire logic SMBUS_CLK_IN,
  input wire logic SMBUS_DATA_IN,
  output logic PCI_CLOCK_STOP_N_OUT,
  output logic PRIMARY_PLANE_OFF_N_OUT,
  output logic SECONDARY_PLANE_OFF_N_OUT,
  output logic TERTIARY_PLANE_OFF_N_OUT,
  output logic POWER_BUTTON_EVENT_OUT,
  output logic POWER_BUTTON_LEVEL_OUT,
  output logic RING_WAKE_EVENT_OUT,
  output logic GP_IN_RING_ALT_OUT,
  output logic GP_IN_ALERT_ALT_OUT,
  output logic ALERT_IRQ_OUT,
  output logic ALERT_RESUME_OUT,
  output logic SMBUS_CLK_OUT,
  output logic SMBUS_CLK_OE_OUT,
  output logic SMBUS_DATA_OUT,
  output logic SMBUS_DATA_OE_OUT
);

  // ****************************************
  // reset and synchronisers
  // ****************************************
  // either reset clears the suspend-well logic
  wire rst = RESET_IN | ~RESUME_RESET_N_IN;

  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic [2:0] prev_reg;
  always_ff @(posedge REF_CLK_IN or posedge rst) begin
    if (rst) begin
      meta_reg <= 3'h7;
      sync_reg <= 3'h7;
      prev_reg <= 3'h7;
    end else begin
      meta_reg <= {SMBUS_ALERT_N_IN, RING_INDICATE_N_IN, POWER_BUTTON_N_IN};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end
  wire pb_sync_n = sync_reg[0];
  wire ring_sync_n = sync_reg[1];
  wire alert_sync_n = sync_reg[2];

  // ****************************************
  // power button debounce
  // ****************************************
  localparam int CW = $clog2(DEBOUNCE_CYC + 1);
  logic [CW-1:0] db_cnt_reg;
  logic pb_stable_n_reg;
  logic pb_event_reg;
  wire pb_differs = pb_sync_n != pb_stable_n_reg;
  wire db_done = db_cnt_reg == CW'(DEBOUNCE_CYC - 1);
  always_ff @(posedge REF_CLK_IN or posedge rst) begin
    if (rst) begin
      db_cnt_reg <= '0;
      pb_stable_n_reg <= 1'b1;
      pb_event_reg <= 1'b0;
    end else begin
      pb_event_reg <= 1'b0;
      if (!pb_differs) begin
        db_cnt_reg <= '0;
      end else if (db_done) begin
        db_cnt_reg <= '0;
        pb_stable_n_reg <= pb_sync_n;
        pb_event_reg <= ~pb_sync_n;
      end else begin
        db_cnt_reg <= db_cnt_reg + CW'(1);
      end
    end
  end
  assign POWER_BUTTON_EVENT_OUT = pb_event_reg;
  assign POWER_BUTTON_LEVEL_OUT = ~pb_stable_n_reg;

  // ****************************************
  // ring indicate and smbus alert
  // ****************************************
  wire ring_fall = prev_reg[1] & ~ring_sync_n;
  wire alert_act = ~alert_sync_n & ~ALERT_GPI_SEL_IN;
  logic ring_wake_reg;
  logic alert_irq_reg;
  logic alert_res_reg;
  always_ff @(posedge REF_CLK_IN or posedge rst) begin
    if (rst) begin
      ring_wake_reg <= 1'b0;
      alert_irq_reg <= 1'b0;
      alert_res_reg <= 1'b0;
    end else begin
      ring_wake_reg <= ring_fall & ~RING_GPI_SEL_IN;
      alert_irq_reg <= alert_act & ALERT_IRQ_EN_IN;
      alert_res_reg <= alert_act & ALERT_RESUME_EN_IN;
    end
  end
  assign RING_WAKE_EVENT_OUT = ring_wake_reg;
  assign ALERT_IRQ_OUT = alert_irq_reg;
  assign ALERT_RESUME_OUT = alert_res_reg;
  // gp inputs read raw synchronised levels
  assign GP_IN_RING_ALT_OUT = ring_sync_n;
  assign GP_IN_ALERT_ALT_OUT = alert_sync_n;

  // ****************************************
  // suspend state and plane controls
  // ****************************************
  spc_state_e state_reg;
  spc_state_e state_next;
  always_comb begin
    case (SUSPEND_REQ_IN)
      SPC_REQ_POS: state_next = SPC_POS;
      SPC_REQ_STR: state_next = SPC_STR;
      SPC_REQ_STD: state_next = SPC_STD;
      default: state_next = SPC_ON;
    endcase
  end

  logic pci_n_reg;
  logic pri_n_reg;
  logic sec_n_reg;
  logic ter_n_reg;
  wire in_pos = state_next == SPC_POS;
  wire deep = (state_next == SPC_STR) | (state_next == SPC_STD);
  wire pri_n = ~(in_pos | deep);
  wire sec_plane_n = ~deep;
  wire sec_n = SECONDARY_GPO_SEL_IN ? GP_OUT_SECONDARY_ALT_IN : sec_plane_n;
  wire ter_plane_n = state_next != SPC_STD;
  wire ter_n = TERTIARY_GPO_SEL_IN ? GP_OUT_TERTIARY_ALT_IN : ter_plane_n;
  wire pci_n = CLKSTOP_GPO_SEL_IN ? GP_OUT_CLKSTOP_ALT_IN : ~PCI_STOP_REQ_IN;

  // plane pins low and clock stop pin high in reset, afterwards they follow the suspend or stop request or the gpo select
  always_ff @(posedge REF_CLK_IN or posedge rst) begin
    if (rst) begin
      state_reg <= SPC_ON;
      pci_n_reg <= 1'b1;
      pri_n_reg <= 1'b0;
      sec_n_reg <= 1'b0;
      ter_n_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pci_n_reg <= pci_n;
      pri_n_reg <= pri_n;
      sec_n_reg <= sec_n;
      ter_n_reg <= ter_n;
    end
  end
  assign PCI_CLOCK_STOP_N_OUT = pci_n_reg;
  assign PRIMARY_PLANE_OFF_N_OUT = pri_n_reg;
  assign SECONDARY_PLANE_OFF_N_OUT = sec_n_reg;
  assign TERTIARY_PLANE_OFF_N_OUT = ter_n_reg;

  // ****************************************
  // smbus pins
  // ****************************************
  // the smbus engine lives elsewhere; this block never drives the pins
  assign SMBUS_CLK_OUT = 1'b0;
  assign SMBUS_CLK_OE_OUT = 1'b0;
  assign SMBUS_DATA_OUT = 1'b0;
  assign SMBUS_DATA_OE_OUT = 1'b0;

  // ****************************************
  // assertions
  // ****************************************
  // the edge on which a reset lets go still leaves reset values on the
  // pins, so state checks wait until the edge after it
  sequence pb_count_end;
    pb_differs && db_done;
  endsequence
  sequence ring_edge_seen;
    ring_fall && !RING_GPI_SEL_IN;
  endsequence
  a_pri_plane_state: assert property (
    @(posedge REF_CLK_IN) disable iff (rst)
    !$past(rst) |-> !PRIMARY_PLANE_OFF_N_OUT == (state_reg != SPC_ON))
    else $error("primary plane mismatches state");
  a_sec_plane_state: assert property (
    @(posedge REF_CLK_IN) disable iff (rst)
    !$past(rst) && !SECONDARY_GPO_SEL_IN && $stable(SECONDARY_GPO_SEL_IN)
    |=> !SECONDARY_PLANE_OFF_N_OUT ==
    (state_reg == SPC_STR || state_reg == SPC_STD))
    else $error("secondary plane mismatches state");
  a_ter_plane_std: assert property (
    @(posedge REF_CLK_IN) disable iff (rst)
    !$past(rst) && !TERTIARY_GPO_SEL_IN
    |=> !TERTIARY_PLANE_OFF_N_OUT == (state_reg == SPC_STD))
    else $error("tertiary plane mismatches state");
  a_pos_sec_high: assert property (
    @(posedge REF_CLK_IN) disable iff (rst)
    !$past(rst) && !SECONDARY_GPO_SEL_IN && SUSPEND_REQ_IN == SPC_REQ_POS
    |=> SECONDARY_PLANE_OFF_N_OUT)
    else $error("secondary low during pos");
  a_pci_stop_req: assert property (
    @(posedge REF_CLK_IN) disable iff (rst)
    !$past(rst) && !CLKSTOP_GPO_SEL_IN
    |=> PCI_CLOCK_STOP_N_OUT == !$past(PCI_STOP_REQ_IN))
    else $error("clock stop pin wrong");
  a_pb_debounce: assert property (
    @(posedge REF_CLK_IN) disable iff (rst)
    POWER_BUTTON_EVENT_OUT |-> db_cnt_reg == '0 && !pb_stable_n_reg
    && $past(pb_sync_n, 1) == 1'b0)
    else $error("button event without debounce");
  a_pb_count_full: assert property (
    @(posedge REF_CLK_IN) disable iff (rst)
    $rose(POWER_BUTTON_LEVEL_OUT) |-> $past(db_done))
    else $error("button level changed early");
  a_pb_commit: assert property (
    @(posedge REF_CLK_IN) disable iff (rst)
    pb_count_end |=> pb_stable_n_reg == $past(pb_sync_n))
    else $error("debounced level not taken");
  a_ring_wake: assert property (
    @(posedge REF_CLK_IN) disable iff (rst)
    ring_edge_seen |=> RING_WAKE_EVENT_OUT)
    else $error("ring wake missed");
  a_alert_gate: assert property (
    @(posedge REF_CLK_IN) disable iff (rst)
    ALERT_IRQ_OUT |-> $past(!alert_sync_n && ALERT_IRQ_EN_IN))
    else $error("alert irq without cause");
  a_smbus_hiz: assert property (
    @(posedge REF_CLK_IN)
    !SMBUS_CLK_OE_OUT && !SMBUS_DATA_OE_OUT)
    else $error("smbus pin driven");
  a_reset_planes: assert property (
    @(posedge REF_CLK_IN)
    rst && $past(rst) |-> !PRIMARY_PLANE_OFF_N_OUT
    && !SECONDARY_PLANE_OFF_N_OUT && !TERTIARY_PLANE_OFF_N_OUT
    && PCI_CLOCK_STOP_N_OUT)
    else $error("planes not low in reset");

endmodule

// ---- verification/spc_suspend_plane_control_tb_top.sv ----
// testbench for the suspend plane control block
`timescale 1ns/1ps
module spc_suspend_plane_control_tb_top
  import spc_pkg::*;
;
  localparam int DBC = 8;
  logic REF_CLK_IN = 0, RESET_IN = 1, RESUME_RESET_N_IN = 1;
  logic [1:0] SUSPEND_REQ_IN = SPC_REQ_ON;
  logic PCI_STOP_REQ_IN = 0, CLKSTOP_GPO_SEL_IN = 0;
  logic SECONDARY_GPO_SEL_IN = 0, TERTIARY_GPO_SEL_IN = 0;
  logic GP_OUT_CLKSTOP_ALT_IN = 0, GP_OUT_SECONDARY_ALT_IN = 0;
  logic GP_OUT_TERTIARY_ALT_IN = 0, RING_GPI_SEL_IN = 0;
  logic ALERT_GPI_SEL_IN = 0, ALERT_IRQ_EN_IN = 0, ALERT_RESUME_EN_IN = 0;
  logic SMBUS_CLK_IN = 0, SMBUS_DATA_IN = 0;
  logic POWER_BUTTON_N_IN, RING_INDICATE_N_IN, SMBUS_ALERT_N_IN;
  logic PCI_CLOCK_STOP_N_OUT, PRIMARY_PLANE_OFF_N_OUT;
  logic SECONDARY_PLANE_OFF_N_OUT, TERTIARY_PLANE_OFF_N_OUT;
  logic POWER_BUTTON_EVENT_OUT, POWER_BUTTON_LEVEL_OUT;
  logic RING_WAKE_EVENT_OUT, GP_IN_RING_ALT_OUT, GP_IN_ALERT_ALT_OUT;
  logic ALERT_IRQ_OUT, ALERT_RESUME_OUT, SMBUS_CLK_OUT, SMBUS_CLK_OE_OUT;
  logic SMBUS_DATA_OUT, SMBUS_DATA_OE_OUT;
  logic press = 0, bounce = 0, ring = 0, alert = 0;
  int err_count = 0, tests_run = 0, cycles = 0, btn_ev = 0, ring_ev = 0;
  // free clock never stops, even with a clock-stop request out
  always #5 REF_CLK_IN = ~REF_CLK_IN;
  spc_suspend_plane_control #(.DEBOUNCE_CYC(DBC)) dut_u (.*);
  spc_wake_model wm_u (.clk_in(REF_CLK_IN), .press_in(press),
    .bounce_in(bounce), .ring_in(ring), .alert_in(alert),
    .button_n_out(POWER_BUTTON_N_IN), .ring_n_out(RING_INDICATE_N_IN),
    .alert_n_out(SMBUS_ALERT_N_IN));
  always @(posedge REF_CLK_IN) begin
    cycles++;
    if (POWER_BUTTON_EVENT_OUT === 1'b1) btn_ev++;
    if (RING_WAKE_EVENT_OUT === 1'b1) ring_ev++;
    if (cycles == 3000) begin
      err_count++;
      end_sim();
    end
  end
  task chk(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge REF_CLK_IN);
    #1;
  endtask
  task planes(input logic p, input logic s, input logic t);
    chk("primary", p, PRIMARY_PLANE_OFF_N_OUT);
    chk("secondary", s, SECONDARY_PLANE_OFF_N_OUT);
    chk("tertiary", t, TERTIARY_PLANE_OFF_N_OUT);
    chk("smb_oe", 1'b0, SMBUS_CLK_OE_OUT | SMBUS_DATA_OE_OUT);
    chk("smb_out", 1'b0, SMBUS_CLK_OUT | SMBUS_DATA_OUT);
  endtask
  task t_reset;
    tick(1);
    planes(0, 0, 0);
    chk("pci_rst", 1'b1, PCI_CLOCK_STOP_N_OUT);
    @(posedge REF_CLK_IN) RESET_IN <= 0;
    tick(2);
    planes(1, 1, 1);
    @(posedge REF_CLK_IN) RESUME_RESET_N_IN <= 0;
    tick(2);
    planes(0, 0, 0);
    @(posedge REF_CLK_IN) RESUME_RESET_N_IN <= 1;
    tick(2);
    planes(1, 1, 1);
  endtask
  task t_states;
    for (int i = 0; i < 4; i++) begin
      @(posedge REF_CLK_IN) SUSPEND_REQ_IN <= 2'(i);
      tick(2);
      planes(i == 0, i < 2, i != 3);
    end
  endtask
  task t_gpo;
    @(posedge REF_CLK_IN) SUSPEND_REQ_IN <= SPC_REQ_POS;
    @(posedge REF_CLK_IN) PCI_STOP_REQ_IN <= 1;
    tick(2);
    chk("pci_stop", 1'b0, PCI_CLOCK_STOP_N_OUT);
    @(posedge REF_CLK_IN) begin
      {CLKSTOP_GPO_SEL_IN, SECONDARY_GPO_SEL_IN, TERTIARY_GPO_SEL_IN} <= 3'h7;
      GP_OUT_CLKSTOP_ALT_IN <= 1;
      GP_OUT_TERTIARY_ALT_IN <= 0;
    end
    tick(2);
    chk("pci_gpo", 1'b1, PCI_CLOCK_STOP_N_OUT);
    planes(0, 0, 0);
    @(posedge REF_CLK_IN) begin
      {CLKSTOP_GPO_SEL_IN, SECONDARY_GPO_SEL_IN, TERTIARY_GPO_SEL_IN} <= 0;
      PCI_STOP_REQ_IN <= 0;
    end
    tick(2);
    chk("pci_run", 1'b1, PCI_CLOCK_STOP_N_OUT);
  endtask
  task t_button;
    @(posedge REF_CLK_IN) bounce <= 1;
    tick(3 * DBC);
    chk("bounce_ev", 1'b1, btn_ev == 0);
    @(posedge REF_CLK_IN) begin
      bounce <= 0;
      press <= 1;
    end
    tick(DBC);
    chk("early_ev", 1'b1, btn_ev == 0);
    tick(6);
    chk("press_ev", 1'b1, btn_ev == 1);
    chk("btn_level", 1'b1, POWER_BUTTON_LEVEL_OUT);
    @(posedge REF_CLK_IN) press <= 0;
    tick(DBC + 6);
    chk("release", 1'b1, btn_ev == 1 && POWER_BUTTON_LEVEL_OUT === 0);
  endtask
  task t_ring_alert;
    @(posedge REF_CLK_IN) ring <= 1;
    tick(6);
    chk("ring_ev", 1'b1, ring_ev == 1);
    @(posedge REF_CLK_IN) begin
      ring <= 0;
      RING_GPI_SEL_IN <= 1;
    end
    tick(3);
    @(posedge REF_CLK_IN) ring <= 1;
    tick(6);
    chk("ring_gpi", 1'b1, ring_ev == 1 && GP_IN_RING_ALT_OUT === 0);
    @(posedge REF_CLK_IN) begin
      alert <= 1;
      ALERT_IRQ_EN_IN <= 1;
    end
    tick(4);
    chk("irq", 1'b1, ALERT_IRQ_OUT & ~ALERT_RESUME_OUT);
    @(posedge REF_CLK_IN) {ALERT_IRQ_EN_IN, ALERT_RESUME_EN_IN} <= 2'h1;
    tick(2);
    chk("resume", 1'b1, ~ALERT_IRQ_OUT & ALERT_RESUME_OUT);
    @(posedge REF_CLK_IN) ALERT_GPI_SEL_IN <= 1;
    tick(2);
    chk("alert_gpi", 1'b0, ALERT_RESUME_OUT | GP_IN_ALERT_ALT_OUT);
  endtask
  task end_sim;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    tick(3);
    t_reset();
    t_states();
    t_gpo();
    t_button();
    t_ring_alert();
    end_sim();
  end
endmodule

// ---- verification/spc_wake_model.sv ----
// wake source model: power button, ring indicate and alert pins
`timescale 1ns/1ps
module spc_wake_model (
  input wire logic clk_in,
  input wire logic press_in,
  input wire logic bounce_in,
  input wire logic ring_in,
  input wire logic alert_in,
  output logic button_n_out = 1'b1,
  output logic ring_n_out,
  output logic alert_n_out
);
  // a bouncing contact flips every cycle, never settling
  always @(posedge clk_in) begin
    button_n_out <= bounce_in ? ~button_n_out : ~press_in;
  end
  assign ring_n_out = ~ring_in;
  assign alert_n_out = ~alert_in;
endmodule
